// File: include/omps_defines.svh
// Functional notes
// - A low mode pin selects hardware mode, the family pin becomes the line code strap and shared pins act as straps.
// - A high mode pin with the family pin low selects the data-strobe bus with R/W, AS, DS and active-low ACK.
// - A high mode pin with the family pin high selects the read/write-strobe bus with RD, WR, ALE and RDY.
// - A mid-level mode pin selects the serial port with SCLK, SDI, SDO and chip select, whatever the family pin.
// - The serial port works the same for both families; data lines are grounded and unused lines left open.
// - Hardware mode uses A3..A0 as monitor channel, the family pin as code strap and shared pins as jitter and loopback straps.
`ifndef OMPS_DEFINES_SVH
`define OMPS_DEFINES_SVH

// Register byte offsets
`define OMPS_ADR_CTRL   4'h0
`define OMPS_ADR_STAT   4'h4
`define OMPS_ADR_STRAP  4'h8
`define OMPS_ADR_ERR    4'hc

// Control fields and reset value
`define OMPS_CTRL_PINEN 0
`define OMPS_CTRL_RESMP 1
`define OMPS_CTRL_RST   2'h1

// Status fields
`define OMPS_STAT_LOCK  2
`define OMPS_STAT_MID   3
`define OMPS_STAT_FAM   4

// Error fields, write one to clear
`define OMPS_ERR_HWGND  0
`define OMPS_ERR_SERGND 1

// Strap settling time before capture
`define OMPS_SETTLE_NS  100
`define OMPS_CLK_MHZ    250
`define OMPS_SETTLE_CYC ((`OMPS_SETTLE_NS * `OMPS_CLK_MHZ + 999) / 1000)

`endif

// File: include/omps_pkg.sv
package omps_pkg;

  // Operating modes
  typedef enum logic [1:0] {
    OMPS_HW,
    OMPS_PAR_DS,
    OMPS_PAR_RW,
    OMPS_SERIAL
  } omps_mode_type;

  // Strap capture states
  typedef enum logic {
    ST_SETTLE,
    ST_LOCKED
  } omps_cap_type;

endpackage

// File: verilog/omps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module omps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_r <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: verilog/omps_level_decode.sv
`timescale 1ns/10ps
`default_nettype none
module omps_level_decode
  import omps_pkg::*;
(
  input  wire logic    mode_hi_in,
  input  wire logic    mode_lo_in,
  input  wire logic    family_in,
  output omps_mode_type mode_out,
  output logic          mid_out
);

  // Window comparator pair: neither threshold crossed means half supply
  assign mid_out = !mode_hi_in && !mode_lo_in;

  // An impossible both-set pair falls back to hardware mode, the safe choice
  always_comb
  begin
    if (mode_lo_in)
      mode_out = OMPS_HW;
    else if (mode_hi_in)
      mode_out = family_in ? OMPS_PAR_RW : OMPS_PAR_DS;
    else
      mode_out = OMPS_SERIAL;
  end

endmodule
`default_nettype wire

// File: verilog/omps_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "omps_defines.svh"
module omps_top
  import omps_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [3:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        MODE_HI_IN,
  input  wire logic        MODE_LO_IN,
  input  wire logic        FAMSEL_IN,
  input  wire logic [4:0]  ADDR_IN,
  input  wire logic        CSN_IN,
  input  wire logic        RW_IN,
  input  wire logic        AS_IN,
  input  wire logic        DS_IN,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE_OUT,
  output logic             ACK_OUT,
  output logic             ACK_OE_OUT,
  input  wire logic [7:0]  CORE_RDATA_IN,
  input  wire logic        CORE_ACK_IN,
  input  wire logic        CORE_SDO_IN,
  output logic      [1:0]  MODE_OUT,
  output logic             CFG_VALID_OUT,
  output logic      [4:0]  HOST_ADDR_OUT,
  output logic      [7:0]  HOST_WDATA_OUT,
  output logic             HOST_RD_OUT,
  output logic             HOST_WR_OUT,
  output logic             SER_SCLK_OUT,
  output logic             SER_SDI_OUT,
  output logic             SER_CSN_OUT,
  output logic             LINE_CODE_SEL_OUT,
  output logic             JITTER_PATH_SEL_OUT,
  output logic      [7:0]  LOOPBACK_SEL_OUT,
  output logic      [3:0]  PM_CHANNEL_OUT
);

  localparam logic [4:0] SETTLE_CNT = 5'(`OMPS_SETTLE_CYC);

  logic [19:0]   pins_s;
  logic          mode_hi_s;
  logic          mode_lo_s;
  logic          fam_s;
  logic          csn_s;
  logic          rw_s;
  logic          as_s;
  logic          ds_s;
  logic [4:0]    addr_s;
  logic [7:0]    data_s;
  omps_mode_type live_mode;
  logic          live_mid;
  omps_cap_type  cap_r;
  omps_cap_type  cap_nxt;
  logic [4:0]    cnt_r;
  omps_mode_type mode_r;
  logic          rw_p_r;
  logic          ds_p_r;
  logic          done_r;
  logic [1:0]    ctrl_r;
  logic [1:0]    err_r;
  logic [1:0]    err_nxt;

  // All pin inputs pass two flip-flops before use
  omps_sync #(
    .WIDTH (20)
  ) u_sync (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .d_in      ({MODE_HI_IN, MODE_LO_IN, FAMSEL_IN, CSN_IN, RW_IN,
                 AS_IN, DS_IN, ADDR_IN, DATA_IN}),
    .q_out     (pins_s)
  );

  assign {mode_hi_s, mode_lo_s, fam_s, csn_s, rw_s, as_s, ds_s, addr_s, data_s} = pins_s;

  omps_level_decode u_dec (
    .mode_hi_in (mode_hi_s),
    .mode_lo_in (mode_lo_s),
    .family_in  (fam_s),
    .mode_out   (live_mode),
    .mid_out    (live_mid)
  );

  // Bus decode
  wire bus_req  = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  // Writes land on the edge where the master sees ack, not on the taking edge
  wire bus_wr   = WB_CYC_IN && WB_STB_IN && WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0];
  wire wr_ctrl  = bus_wr && (WB_ADR_IN == `OMPS_ADR_CTRL);
  wire wr_err   = bus_wr && (WB_ADR_IN == `OMPS_ADR_ERR);
  wire resample = wr_ctrl && WB_DAT_IN[`OMPS_CTRL_RESMP];
  wire pin_en   = ctrl_r[`OMPS_CTRL_PINEN];

  // Mode qualifiers, all false until the straps are locked
  wire locked  = (cap_r == ST_LOCKED);
  wire is_hw   = locked && (mode_r == OMPS_HW);
  wire is_ds   = locked && (mode_r == OMPS_PAR_DS);
  wire is_rw   = locked && (mode_r == OMPS_PAR_RW);
  wire is_ser  = locked && (mode_r == OMPS_SERIAL);

  // Strobe edges on synchronised pins
  wire ds_fall = ds_p_r && !ds_s;
  wire ds_rise = !ds_p_r && ds_s;
  wire rd_fall = rw_p_r && !rw_s;
  wire sel     = !csn_s;

  // Host strobes per bus family
  wire rd_go   = sel && ((is_ds && ds_fall && rw_s) || (is_rw && rd_fall));
  wire wr_go   = sel && ((is_ds && ds_rise && !rw_s) || (is_rw && ds_rise));
  wire strobe  = sel && ((is_ds && !ds_s) || (is_rw && (!rw_s || !ds_s)));
  wire rd_act  = sel && ((is_ds && !ds_s && rw_s) || (is_rw && !rw_s));

  // Address latch: AS active low, ALE active high; transparent while open
  wire addr_open = (is_ds && !as_s) || (is_rw && as_s);

  // Grounding checks for unused pins
  wire hw_gnd_bad  = is_hw && (addr_s[4] || rw_s || as_s || ds_s);
  wire ser_gnd_bad = is_ser && (data_s != 8'h00);

  // Sticky errors; a new event beats a clear in the same cycle
  assign err_nxt = (err_r & ~(wr_err ? WB_DAT_IN[1:0] : 2'h0))
                 | {ser_gnd_bad, hw_gnd_bad};

  // Capture sequence: settle, then freeze the decoded mode
  always_comb
  begin
    cap_nxt = cap_r;
    case (cap_r)
      ST_SETTLE: if (cnt_r == 5'h00) cap_nxt = ST_LOCKED;
      ST_LOCKED: if (resample) cap_nxt = ST_SETTLE;
      default:   cap_nxt = ST_SETTLE;
    endcase
  end

  // Strap capture; mode is not taken during reset but after release
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      cap_r  <= ST_SETTLE;
      cnt_r  <= SETTLE_CNT;
      mode_r <= OMPS_HW;
    end
    else
    begin
      cap_r <= cap_nxt;
      cnt_r <= (cap_nxt == ST_SETTLE && cap_r == ST_LOCKED) ? SETTLE_CNT
             : (cnt_r != 5'h00) ? cnt_r - 5'h01 : cnt_r;
      if (cap_r == ST_SETTLE && cap_nxt == ST_LOCKED)
        mode_r <= live_mode;
    end
  end

  // Register file and edge history
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_r <= `OMPS_CTRL_RST;
      err_r  <= 2'h0;
      rw_p_r <= 1'b1;
      ds_p_r <= 1'b1;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= {1'b0, WB_DAT_IN[`OMPS_CTRL_PINEN]};
      err_r  <= err_nxt;
      rw_p_r <= rw_s;
      ds_p_r <= ds_s;
    end
  end

  // Read mux; unmapped offsets read zero
  wire [31:0] stat_word  = {27'h0, fam_s, live_mid, locked, 2'(mode_r)};
  wire [31:0] strap_word = {18'h0, JITTER_PATH_SEL_OUT, LINE_CODE_SEL_OUT,
                            PM_CHANNEL_OUT, LOOPBACK_SEL_OUT};
  wire [31:0] rd_word    = (WB_ADR_IN == `OMPS_ADR_CTRL)  ? {30'h0, ctrl_r}
                         : (WB_ADR_IN == `OMPS_ADR_STAT)  ? stat_word
                         : (WB_ADR_IN == `OMPS_ADR_STRAP) ? strap_word
                         : (WB_ADR_IN == `OMPS_ADR_ERR)   ? {30'h0, err_r}
                         : 32'h0;

  // Single-wait-state slave: ack one cycle after the request
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end
    else
    begin
      WB_ACK_OUT <= bus_req;
      WB_DAT_OUT <= bus_req ? rd_word : 32'h0;
    end
  end

  // Hardware-mode straps; zero in host modes so no stray loopback appears
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      LINE_CODE_SEL_OUT   <= 1'b0;
      JITTER_PATH_SEL_OUT <= 1'b0;
      LOOPBACK_SEL_OUT    <= 8'h00;
      PM_CHANNEL_OUT      <= 4'h0;
    end
    else
    begin
      LINE_CODE_SEL_OUT   <= is_hw && fam_s;
      JITTER_PATH_SEL_OUT <= is_hw && csn_s;
      LOOPBACK_SEL_OUT    <= is_hw ? data_s : 8'h00;
      PM_CHANNEL_OUT      <= is_hw ? addr_s[3:0] : 4'h0;
    end
  end

  // Parallel host decode toward the register core
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      HOST_ADDR_OUT  <= 5'h00;
      HOST_WDATA_OUT <= 8'h00;
      HOST_RD_OUT    <= 1'b0;
      HOST_WR_OUT    <= 1'b0;
      done_r         <= 1'b0;
    end
    else
    begin
      if (addr_open)
        HOST_ADDR_OUT <= addr_s;
      if (wr_go)
        HOST_WDATA_OUT <= data_s;
      HOST_RD_OUT <= rd_go;
      HOST_WR_OUT <= wr_go;
      done_r      <= strobe && (done_r || CORE_ACK_IN);
    end
  end

  // Pin drivers; acknowledge sense flips between the two families
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      DATA_OUT     <= 8'h00;
      DATA_OE_OUT  <= 1'b0;
      ACK_OUT      <= 1'b1;
      ACK_OE_OUT   <= 1'b0;
      SER_SCLK_OUT <= 1'b0;
      SER_SDI_OUT  <= 1'b0;
      SER_CSN_OUT  <= 1'b1;
    end
    else
    begin
      DATA_OUT    <= rd_act ? CORE_RDATA_IN : 8'h00;
      DATA_OE_OUT <= pin_en && rd_act;
      ACK_OUT     <= is_ser ? CORE_SDO_IN
                   : is_rw  ? done_r : !done_r;
      ACK_OE_OUT  <= pin_en && (strobe || (is_ser && sel));
      SER_SCLK_OUT <= is_ser && as_s;
      SER_SDI_OUT  <= is_ser && ds_s;
      SER_CSN_OUT  <= !(is_ser && sel);
    end
  end

  // Mode report
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      MODE_OUT      <= 2'h0;
      CFG_VALID_OUT <= 1'b0;
    end
    else
    begin
      MODE_OUT      <= 2'(mode_r);
      CFG_VALID_OUT <= locked;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_ds_read;
    is_ds && sel && rw_s && ds_fall;
  endsequence

  sequence s_rd_pulse;
    HOST_RD_OUT ##1 !HOST_RD_OUT;
  endsequence

  a_hw_no_strobe: assert property (is_hw |=> !HOST_RD_OUT && !HOST_WR_OUT)
    else $error("host strobe in hardware mode");

  a_ds_read_pulse: assert property (s_ds_read |=> s_rd_pulse)
    else $error("data-strobe read not one pulse");

  a_rw_write_edge: assert property (is_rw && sel && ds_rise |=> HOST_WR_OUT)
    else $error("write strobe missed");

  a_serial_clock: assert property (is_ser ##1 is_ser |-> SER_SCLK_OUT == $past(as_s))
    else $error("shift clock not passed");

  a_serial_ground: assert property (ser_gnd_bad |=> err_r[`OMPS_ERR_SERGND])
    else $error("serial data ground fault lost");

  a_hw_loopback: assert property (is_hw ##1 is_hw |-> LOOPBACK_SEL_OUT == $past(data_s))
    else $error("loopback strap not followed");

  a_mode_static: assert property (locked && !resample |=> $stable(mode_r) && locked)
    else $error("mode changed while locked");

  a_settle_hold: assert property ($fell(locked) |-> !locked [*8])
    else $error("settle period too short");

  a_bus_ack_once: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held two cycles");

endmodule
`default_nettype wire

// File: bench/omps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host processor and board straps on the shared pins, plus the register core's acknowledge
module omps_host_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  output logic             core_ack_out,
  output logic      [16:0] pins_out
);
  int cnt;

  // Every shared pin rests at ground until a phase lifts it
  initial
  begin
    cnt = 0;
    core_ack_out = 1'b0;
    pins_out = 17'h0;
  end

  // Core answers late on purpose so the pin handshake must wait for it
  always @(posedge clk_in)
  begin
    if (rd_in || wr_in)
      cnt <= ACK_DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    core_ack_out <= (cnt == 1);
  end

  // Pin order: address, select, rw, address strobe, data strobe, data
  task automatic put(input logic [16:0] v, input int n);
    pins_out <= v;
    repeat (n) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import omps_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        m_hi = 1'b0;
  logic        m_lo = 1'b1;
  logic        fam = 1'b0;
  logic        sdo = 1'b0;
  logic [31:0] rdat;
  logic [16:0] pins;
  logic [7:0]  dout, hwdata, loop, data_w;
  logic [4:0]  haddr;
  logic [3:0]  pm;
  logic [1:0]  mode;
  logic        ack, doe, ack_o, ack_oe, c_ack, valid, h_rd, h_wr, sclk, sdi, scsn, lcs, jps;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_rd = 0;
  int          n_wr = 0;

  always #2 clk = ~clk;

  // Data pins carry the device's value only while it drives them
  assign data_w = doe ? dout : pins[7:0];

  omps_top u_omps_top (
    .CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .MODE_HI_IN(m_hi), .MODE_LO_IN(m_lo), .FAMSEL_IN(fam), .ADDR_IN(pins[16:12]),
    .CSN_IN(pins[11]), .RW_IN(pins[10]), .AS_IN(pins[9]), .DS_IN(pins[8]), .DATA_IN(data_w),
    .DATA_OUT(dout), .DATA_OE_OUT(doe), .ACK_OUT(ack_o), .ACK_OE_OUT(ack_oe),
    .CORE_RDATA_IN(8'h3c), .CORE_ACK_IN(c_ack), .CORE_SDO_IN(sdo), .MODE_OUT(mode),
    .CFG_VALID_OUT(valid), .HOST_ADDR_OUT(haddr), .HOST_WDATA_OUT(hwdata), .HOST_RD_OUT(h_rd),
    .HOST_WR_OUT(h_wr), .SER_SCLK_OUT(sclk), .SER_SDI_OUT(sdi), .SER_CSN_OUT(scsn),
    .LINE_CODE_SEL_OUT(lcs), .JITTER_PATH_SEL_OUT(jps), .LOOPBACK_SEL_OUT(loop),
    .PM_CHANNEL_OUT(pm)
  );

  omps_host_model u_host (
    .clk_in(clk), .rd_in(h_rd), .wr_in(h_wr), .core_ack_out(c_ack), .pins_out(pins)
  );

  // Pulse counters and the hang guard; a run needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (h_rd === 1'b1)
      n_rd <= n_rd + 1;
    if (h_wr === 1'b1)
      n_wr <= n_wr + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the bench's own timeout ends this wait
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask

  // Mode pins are set before release so the capture sees them steady
  task automatic boot(input logic h, input logic l, input logic f, input omps_mode_type e);
    rst_n <= 1'b0;
    m_hi <= h;
    m_lo <= l;
    fam <= f;
    u_host.put(17'h0, 12);
    rst_n <= 1'b1;
    repeat (60)
    begin
      @(posedge clk);
      if (valid === 1'b1)
        break;
    end
    chk("cfg_valid", 1, valid);
    chk("mode", e, mode);
  endtask

  task automatic hw_straps();
    logic [31:0] q;
    // Chip-select pin doubles as the jitter path strap, so lift it once
    u_host.put({5'h09, 4'b1000, 8'ha5}, 5);
    chk("loop", 8'ha5, loop);
    chk("chan", 4'h9, pm);
    chk("code", 1, lcs);
    chk("jpath", 1, jps);
    chk("d_oe", 0, doe);
    wb(1'b0, 4'h8, 0, q);
    chk("strap", 32'h39a5, q);
    wb(1'b0, 4'h4, 0, q);
    chk("stat", 32'h14, q);
    wb(1'b0, 4'h0, 0, q);
    chk("ctrl", 32'h1, q);
    wb(1'b0, 4'h2, 0, q);
    chk("unmapped", 32'h0, q);
    // A strobe left high in strap mode is a fault; clearing cannot win while it stands
    u_host.put({5'h09, 4'b0001, 8'ha5}, 5);
    wb(1'b0, 4'hc, 0, q);
    chk("gnd_err", 32'h1, q);
    wb(1'b1, 4'hc, 32'h1, q);
    wb(1'b0, 4'hc, 0, q);
    chk("gnd_hold", 32'h1, q);
    u_host.put({5'h09, 4'b0000, 8'ha5}, 5);
    wb(1'b1, 4'hc, 32'h1, q);
    wb(1'b0, 4'hc, 0, q);
    chk("gnd_clr", 32'h0, q);
  endtask

  task automatic bus_ds();
    logic [31:0] q;
    int r0;
    int w0;
    u_host.put({5'h15, 4'b0101, 8'h00}, 4);
    r0 = n_rd;
    w0 = n_wr;
    u_host.put({5'h15, 4'b0111, 8'h00}, 4);
    u_host.put({5'h15, 4'b0110, 8'h00}, 14);
    chk("rd_cnt", r0 + 1, n_rd);
    chk("addr", 5'h15, haddr);
    chk("d_oe", 1, doe);
    chk("d_out", 8'h3c, dout);
    chk("ack_low", 2'b10, {ack_oe, ack_o});
    // R/W only moves while DS is high; moving both at once reads as a write
    u_host.put({5'h15, 4'b0111, 8'h5a}, 4);
    u_host.put({5'h15, 4'b0011, 8'h5a}, 4);
    u_host.put({5'h15, 4'b0010, 8'h5a}, 4);
    u_host.put({5'h15, 4'b0011, 8'h5a}, 8);
    chk("wr_cnt", w0 + 1, n_wr);
    chk("wdata", 8'h5a, hwdata);
    // Pins moved after lock must not change the captured mode
    m_hi <= 1'b0;
    fam <= 1'b1;
    repeat (6) @(posedge clk);
    chk("mode_hold", OMPS_PAR_DS, mode);
    // A resample write drops the lock and captures the moved pins afresh
    wb(1'b1, 4'h0, 32'h3, q);
    repeat (4) @(posedge clk);
    chk("resettle", 0, valid);
    repeat (40) @(posedge clk);
    chk("re_mode", OMPS_SERIAL, mode);
    wb(1'b0, 4'h0, 0, q);
    chk("ctrl_self_clr", 32'h1, q);
  endtask

  task automatic bus_rw();
    logic [31:0] q;
    int r0;
    int w0;
    // Both strobes sit low after boot; lifting WR makes one stray write, so counts start after it lands
    u_host.put({5'h0a, 4'b0111, 8'h00}, 6);
    r0 = n_rd;
    w0 = n_wr;
    u_host.put({5'h0a, 4'b0101, 8'h00}, 4);
    u_host.put({5'h0a, 4'b0001, 8'h00}, 14);
    chk("rd_cnt", r0 + 1, n_rd);
    chk("addr", 5'h0a, haddr);
    chk("d_out", 8'h3c, dout);
    chk("rdy_high", 2'b11, {ack_oe, ack_o});
    u_host.put({5'h0a, 4'b0101, 8'hc3}, 4);
    u_host.put({5'h0a, 4'b0100, 8'hc3}, 4);
    u_host.put({5'h0a, 4'b0101, 8'hc3}, 8);
    chk("wr_cnt", w0 + 1, n_wr);
    chk("wdata", 8'hc3, hwdata);
    // With the pin drivers disabled a read must leave the data bus alone
    wb(1'b1, 4'h0, 32'h0, q);
    u_host.put({5'h0a, 4'b0001, 8'h00}, 14);
    chk("d_oe_off", 0, doe);
  endtask

  task automatic serial();
    logic [31:0] q;
    int p0;
    p0 = n_rd + n_wr;
    sdo <= 1'b0;
    u_host.put({5'h00, 4'b0011, 8'h00}, 5);
    chk("sclk", 1, sclk);
    chk("sdi", 1, sdi);
    chk("scsn", 0, scsn);
    chk("sdo_lo", 0, ack_o);
    sdo <= 1'b1;
    u_host.put({5'h00, 4'b0000, 8'h00}, 5);
    chk("sclk_lo", 0, sclk);
    chk("sdo_hi", 1, ack_o);
    chk("no_bus", p0, n_rd + n_wr);
    u_host.put({5'h00, 4'b0000, 8'h01}, 5);
    wb(1'b0, 4'hc, 0, q);
    chk("ser_err", 32'h2, q);
  endtask

  initial
  begin
    boot(1'b0, 1'b1, 1'b1, OMPS_HW);
    hw_straps();
    boot(1'b1, 1'b1, 1'b0, OMPS_HW);
    boot(1'b1, 1'b0, 1'b0, OMPS_PAR_DS);
    bus_ds();
    boot(1'b1, 1'b0, 1'b1, OMPS_PAR_RW);
    bus_rw();
    boot(1'b0, 1'b0, 1'b0, OMPS_SERIAL);
    boot(1'b0, 1'b0, 1'b1, OMPS_SERIAL);
    serial();
    wrap_up();
  end
endmodule
`default_nettype wire
